// File: hw/t16wm_timer.v
// Purpose: Waveform mode logic of a 16-bit timer/counter
// Assumes: All control inputs come from logic on sys_clk_in
// Notes: Flags are one-cycle event pulses; software keeps sticky copies
`timescale 1ns/100ps
`default_nettype none
`include "t16wm_consts.vh"
module t16wm_timer #(
  parameter WIDTH = 16
) (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [2:0] clk_sel_in,
  input wire [3:0] waveform_mode_sel_in,
  input wire [1:0] compare_a_output_mode_in,
  input wire [1:0] compare_b_output_mode_in,
  input wire pin_direction_a_in,
  input wire pin_direction_b_in,
  input wire [WIDTH-1:0] compare_a_wdata_in,
  input wire compare_a_we_in,
  input wire [WIDTH-1:0] compare_b_wdata_in,
  input wire compare_b_we_in,
  input wire [WIDTH-1:0] capture_top_wdata_in,
  input wire capture_top_we_in,
  input wire [WIDTH-1:0] count_wdata_in,
  input wire count_we_in,
  output reg [WIDTH-1:0] count_value_out,
  output reg [WIDTH-1:0] compare_a_value_out,
  output reg [WIDTH-1:0] compare_b_value_out,
  output reg [WIDTH-1:0] capture_top_value_out,
  output reg compare_a_flag_out,
  output reg compare_b_flag_out,
  output reg capture_flag_out,
  output reg overflow_flag_out,
  output reg wave_out_a_out,
  output reg wave_out_b_out,
  output reg wave_out_a_oe_out,
  output reg wave_out_b_oe_out
);
  wire tick;
  reg [WIDTH-1:0] count;
  reg [WIDTH-1:0] cmp_a_buf;
  reg [WIDTH-1:0] cmp_b_buf;
  reg [WIDTH-1:0] cmp_a_act;
  reg [WIDTH-1:0] cmp_b_act;
  reg [WIDTH-1:0] cap_top;
  reg count_down;
  reg block_match;
  reg wave_a;
  reg wave_b;
  reg is_ctc, is_fast, is_pc, top_is_a, top_is_cap, buffered;
  reg [WIDTH-1:0] top;
  reg [WIDTH-1:0] next_count;
  reg next_down;
  reg at_top, at_max, at_bottom, match_a, match_b;

  t16wm_prescaler u_pre (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_sel_in(clk_sel_in),
    .tick_out(tick)
  );

  // Masks a written compare value to the fixed resolution
  function [WIDTH-1:0] mask_fixed;
    input [3:0] mode;
    input [WIDTH-1:0] val;
    begin
      case (mode)
        `T16WM_MODE_PC8, `T16WM_MODE_FP8: mask_fixed = val & `T16WM_TOP_8;
        `T16WM_MODE_PC9, `T16WM_MODE_FP9: mask_fixed = val & `T16WM_TOP_9;
        `T16WM_MODE_PC10, `T16WM_MODE_FP10: mask_fixed = val & `T16WM_TOP_10;
        default: mask_fixed = val;
      endcase
    end
  endfunction

  // Output action for one channel on its compare match
  function next_wave;
    input [1:0] com;
    input cur;
    input fast;
    input pc;
    input down;
    input toggle_ok;
    begin
      next_wave = cur;
      if (com == `T16WM_COM_TOGGLE && toggle_ok)
        next_wave = ~cur;
      else if (fast && com == `T16WM_COM_CLEAR)
        next_wave = 1'b1;
      else if (fast && com == `T16WM_COM_SET)
        next_wave = 1'b0;
      else if (pc && com == `T16WM_COM_CLEAR)
        next_wave = down;
      else if (pc && com == `T16WM_COM_SET)
        next_wave = ~down;
      else if (!fast && !pc && com == `T16WM_COM_CLEAR)
        next_wave = 1'b0;
      else if (!fast && !pc && com == `T16WM_COM_SET)
        next_wave = 1'b1;
    end
  endfunction

  always @* begin
    is_ctc = (waveform_mode_sel_in == `T16WM_MODE_CTC_A) ||
             (waveform_mode_sel_in == `T16WM_MODE_CTC_CAP);
    is_fast = (waveform_mode_sel_in == `T16WM_MODE_FP8) ||
              (waveform_mode_sel_in == `T16WM_MODE_FP9) ||
              (waveform_mode_sel_in == `T16WM_MODE_FP10) ||
              (waveform_mode_sel_in == `T16WM_MODE_FP_CAP) ||
              (waveform_mode_sel_in == `T16WM_MODE_FP_A);
    is_pc = (waveform_mode_sel_in == `T16WM_MODE_PC8) ||
            (waveform_mode_sel_in == `T16WM_MODE_PC9) ||
            (waveform_mode_sel_in == `T16WM_MODE_PC10) ||
            (waveform_mode_sel_in == `T16WM_MODE_PC_CAP) ||
            (waveform_mode_sel_in == `T16WM_MODE_PC_A);
    top_is_a = (waveform_mode_sel_in == `T16WM_MODE_CTC_A) ||
               (waveform_mode_sel_in == `T16WM_MODE_FP_A) ||
               (waveform_mode_sel_in == `T16WM_MODE_PC_A);
    top_is_cap = (waveform_mode_sel_in == `T16WM_MODE_CTC_CAP) ||
                 (waveform_mode_sel_in == `T16WM_MODE_FP_CAP) ||
                 (waveform_mode_sel_in == `T16WM_MODE_PC_CAP);
    buffered = is_fast || is_pc;
    // Top source per mode
    case (waveform_mode_sel_in)
      `T16WM_MODE_PC8, `T16WM_MODE_FP8: top = `T16WM_TOP_8;
      `T16WM_MODE_PC9, `T16WM_MODE_FP9: top = `T16WM_TOP_9;
      `T16WM_MODE_PC10, `T16WM_MODE_FP10: top = `T16WM_TOP_10;
      default: begin
        if (top_is_cap)
          top = cap_top;
        else if (top_is_a)
          top = cmp_a_act;
        else
          top = `T16WM_MAX;
      end
    endcase
    // Exact equality only: a top below the count is missed until wrap
    at_top = (count == top) && !block_match;
    at_max = (count == `T16WM_MAX);
    at_bottom = (count == `T16WM_BOTTOM);
    match_a = (count == cmp_a_act) && !block_match;
    match_b = (count == cmp_b_act) && !block_match;
    next_down = count_down;
    if (is_pc) begin
      if (count_down) begin
        if (at_bottom) begin
          next_count = count + 16'h0001;
          next_down = 1'b0;
        end else
          next_count = count - 16'h0001;
      end else if (at_top) begin
        next_count = count - 16'h0001;
        next_down = 1'b1;
      end else
        next_count = count + 16'h0001;
    end else if ((is_ctc || is_fast) && at_top) begin
      next_count = `T16WM_BOTTOM;
      next_down = 1'b0;
    end else begin
      next_count = count + 16'h0001;
      next_down = 1'b0;
    end
  end

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      count <= `T16WM_BOTTOM;
      cmp_a_buf <= `T16WM_BOTTOM;
      cmp_b_buf <= `T16WM_BOTTOM;
      cmp_a_act <= `T16WM_BOTTOM;
      cmp_b_act <= `T16WM_BOTTOM;
      cap_top <= `T16WM_BOTTOM;
      count_down <= 1'b0;
      block_match <= 1'b0;
      wave_a <= 1'b0;
      wave_b <= 1'b0;
      compare_a_flag_out <= 1'b0;
      compare_b_flag_out <= 1'b0;
      capture_flag_out <= 1'b0;
      overflow_flag_out <= 1'b0;
    end else begin
      compare_a_flag_out <= 1'b0;
      compare_b_flag_out <= 1'b0;
      capture_flag_out <= 1'b0;
      overflow_flag_out <= 1'b0;
      if (capture_top_we_in)
        cap_top <= capture_top_wdata_in;
      if (compare_a_we_in)
        cmp_a_buf <= mask_fixed(waveform_mode_sel_in, compare_a_wdata_in);
      if (compare_b_we_in)
        cmp_b_buf <= mask_fixed(waveform_mode_sel_in, compare_b_wdata_in);
      // Unbuffered modes write the active compare directly
      if (!buffered && compare_a_we_in)
        cmp_a_act <= compare_a_wdata_in;
      if (!buffered && compare_b_we_in)
        cmp_b_act <= compare_b_wdata_in;
      if (count_we_in) begin
        count <= count_wdata_in;
        block_match <= 1'b1;
      end else if (tick) begin
        block_match <= 1'b0;
        count <= next_count;
        count_down <= next_down;
        if (buffered && at_top) begin
          cmp_a_act <= cmp_a_buf;
          cmp_b_act <= cmp_b_buf;
        end
        if (match_a)
          compare_a_flag_out <= 1'b1;
        if (match_b)
          compare_b_flag_out <= 1'b1;
        if (top_is_cap && at_top)
          capture_flag_out <= 1'b1;
        if (is_fast && at_top)
          overflow_flag_out <= 1'b1;
        else if (is_pc && at_bottom)
          overflow_flag_out <= 1'b1;
        else if (!is_fast && !is_pc && at_max)
          overflow_flag_out <= 1'b1;
        // Fast PWM: restore level as the counter passes top to bottom
        if (is_fast && at_top && !match_a &&
            compare_a_output_mode_in[1])
          wave_a <= compare_a_output_mode_in[0];
        else if (match_a)
          wave_a <= next_wave(compare_a_output_mode_in, wave_a, is_fast, is_pc,
                              count_down, !is_fast ||
                              waveform_mode_sel_in == `T16WM_MODE_FP_A);
        if (is_fast && at_top && !match_b &&
            compare_b_output_mode_in[1])
          wave_b <= compare_b_output_mode_in[0];
        else if (match_b)
          wave_b <= next_wave(compare_b_output_mode_in, wave_b, is_fast, is_pc,
                              count_down, !is_fast && !is_pc);
      end
    end
  end

  // Pin drive: level is always registered out; the enable follows the direction
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      count_value_out <= `T16WM_BOTTOM;
      compare_a_value_out <= `T16WM_BOTTOM;
      compare_b_value_out <= `T16WM_BOTTOM;
      capture_top_value_out <= `T16WM_BOTTOM;
      wave_out_a_out <= 1'b0;
      wave_out_b_out <= 1'b0;
      wave_out_a_oe_out <= 1'b0;
      wave_out_b_oe_out <= 1'b0;
    end else begin
      count_value_out <= count;
      compare_a_value_out <= cmp_a_buf;
      compare_b_value_out <= cmp_b_buf;
      capture_top_value_out <= cap_top;
      wave_out_a_out <= wave_a;
      wave_out_b_out <= wave_b;
      wave_out_a_oe_out <= pin_direction_a_in;
      wave_out_b_oe_out <= pin_direction_b_in;
    end
  end
endmodule // t16wm_timer
`default_nettype wire

// File: common/t16wm_consts.vh
// Purpose: Constants for the 16-bit timer waveform mode block
// Assumes: Included by the design files by bare name
// Notes: Mode codes, fixed tops and prescaler selects
`ifndef T16WM_CONSTS_VH
`define T16WM_CONSTS_VH
`define T16WM_MODE_NORMAL 4'h0
`define T16WM_MODE_PC8 4'h1
`define T16WM_MODE_PC9 4'h2
`define T16WM_MODE_PC10 4'h3
`define T16WM_MODE_CTC_A 4'h4
`define T16WM_MODE_FP8 4'h5
`define T16WM_MODE_FP9 4'h6
`define T16WM_MODE_FP10 4'h7
`define T16WM_MODE_PC_CAP 4'hA
`define T16WM_MODE_PC_A 4'hB
`define T16WM_MODE_CTC_CAP 4'hC
`define T16WM_MODE_FP_CAP 4'hE
`define T16WM_MODE_FP_A 4'hF
`define T16WM_TOP_8 16'h00FF
`define T16WM_TOP_9 16'h01FF
`define T16WM_TOP_10 16'h03FF
`define T16WM_MAX 16'hFFFF
`define T16WM_BOTTOM 16'h0000
`define T16WM_COM_NONE 2'h0
`define T16WM_COM_TOGGLE 2'h1
`define T16WM_COM_CLEAR 2'h2
`define T16WM_COM_SET 2'h3
`define T16WM_PRE_STOP 3'h0
`define T16WM_PRE_1 3'h1
`define T16WM_PRE_8 3'h2
`define T16WM_PRE_64 3'h3
`define T16WM_PRE_256 3'h4
`define T16WM_PRE_1024 3'h5
`define T16WM_DIV_8 10'h007
`define T16WM_DIV_64 10'h03F
`define T16WM_DIV_256 10'h0FF
`define T16WM_DIV_1024 10'h3FF
`endif

// File: hw/t16wm_prescaler.v
// Purpose: Timer clock enable from the system clock by a prescaler
// Assumes: Select codes from t16wm_consts.vh
// Notes: Tick is one system clock wide
`timescale 1ns/100ps
`default_nettype none
`include "t16wm_consts.vh"
module t16wm_prescaler (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [2:0] clk_sel_in,
  output reg tick_out
);
  reg [9:0] div_count;
  reg [9:0] div_last;
  always @* begin
    case (clk_sel_in)
      `T16WM_PRE_8: div_last = `T16WM_DIV_8;
      `T16WM_PRE_64: div_last = `T16WM_DIV_64;
      `T16WM_PRE_256: div_last = `T16WM_DIV_256;
      `T16WM_PRE_1024: div_last = `T16WM_DIV_1024;
      default: div_last = 10'h000;
    endcase
  end
  // Free running divider; a select change takes effect within one period
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      div_count <= 10'h000;
      tick_out <= 1'b0;
    end else if (clk_sel_in == `T16WM_PRE_STOP) begin
      div_count <= 10'h000;
      tick_out <= 1'b0;
    end else if (clk_sel_in == `T16WM_PRE_1) begin
      div_count <= 10'h000;
      tick_out <= 1'b1;
    end else if (div_count >= div_last) begin
      div_count <= 10'h000;
      tick_out <= 1'b1;
    end else begin
      div_count <= div_count + 10'h001;
      tick_out <= 1'b0;
    end
  end
endmodule // t16wm_prescaler
`default_nettype wire

// File: bench/t16wm_props.sv
// Purpose: Port checks for t16wm_timer
// Assumes: Count relations are checked with the prescaler at divide by 1
// Notes: q counts quiet cycles, so events still in flight after a change are ignored
`timescale 1ns/100ps
`default_nettype none
module t16wm_props #(
  parameter WIDTH = 16
) (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [2:0] clk_sel_in,
  input wire [3:0] waveform_mode_sel_in,
  input wire [1:0] compare_a_output_mode_in,
  input wire pin_direction_a_in,
  input wire compare_a_we_in,
  input wire compare_b_we_in,
  input wire capture_top_we_in,
  input wire count_we_in,
  input wire [WIDTH-1:0] count_value_out,
  input wire [WIDTH-1:0] compare_a_value_out,
  input wire compare_a_flag_out,
  input wire overflow_flag_out,
  input wire wave_out_a_out,
  input wire wave_out_a_oe_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  reg [1:0] q;
  reg [8:0] pcfg;
  wire [8:0] cfg = {clk_sel_in, waveform_mode_sel_in, compare_a_output_mode_in};
  wire chg = (cfg != pcfg) || compare_a_we_in || compare_b_we_in || capture_top_we_in || count_we_in;
  wire ok = (q == 2'h3) && !chg;
  wire run = ok && (clk_sel_in == 3'h1);
  wire [3:0] m = waveform_mode_sel_in;
  always @(posedge sys_clk_in) begin
    pcfg <= cfg;
    if (sys_rst_in || chg) begin
      q <= 2'h0;
    end else if (q != 2'h3) begin
      q <= q + 2'h1;
    end
  end
  a_ctc_clear: assert property (run && m == 4'h4 && count_value_out == compare_a_value_out
    |=> count_value_out == 16'h0000) else $error("counter not cleared at top");
  a_ctc_flag: assert property (run && m == 4'h4 && count_value_out == compare_a_value_out
    |-> compare_a_flag_out || $past(compare_a_flag_out)) else $error("no top flag");
  a_ctc_ovf: assert property (ok && m == 4'h4 && overflow_flag_out
    |-> count_value_out == 16'hFFFF || count_value_out == 16'h0000) else $error("bad overflow");
  a_fast_wrap: assert property (run && m == 4'h5 && count_value_out == 16'h00FF
    |=> count_value_out == 16'h0000) else $error("fixed top not cleared");
  a_fast_up: assert property (run && m == 4'h5 && count_value_out != 16'h00FF
    |=> count_value_out == $past(count_value_out) + 16'h0001) else $error("not counting up");
  a_top_flags: assert property (ok && m == 4'hF && compare_a_flag_out
    |-> overflow_flag_out) else $error("top flag without overflow");
  a_stop_hold: assert property (ok && clk_sel_in == 3'h0
    |=> $stable(count_value_out) && !overflow_flag_out) else $error("moved while stopped");
  a_mode0_hold: assert property (ok && compare_a_output_mode_in == 2'h0
    |=> $stable(wave_out_a_out)) else $error("output moved in mode zero");
  a_oe_follow: assert property (1'b1
    |=> wave_out_a_oe_out == $past(pin_direction_a_in)) else $error("enable not direction");
endmodule // t16wm_props
`default_nettype wire

// File: bench/testbench.sv
// Purpose: Self-checking bench for t16wm_timer
// Assumes: Inputs change on the falling edge, outputs sampled there too
// Notes: The missed-match wrap costs about 65k cycles, most of the run
`timescale 1ns/100ps
`default_nettype none
module testbench;
  reg sys_clk_in = 1'b0, sys_rst_in = 1'b1, pin_direction_a_in = 1'b0, pin_direction_b_in = 1'b0;
  reg [2:0] clk_sel_in = 3'h0;
  reg [3:0] waveform_mode_sel_in = 4'h0;
  reg [1:0] compare_a_output_mode_in = 2'h0, compare_b_output_mode_in = 2'h0;
  reg [15:0] compare_a_wdata_in = 16'h0000, compare_b_wdata_in = 16'h0000;
  reg [15:0] capture_top_wdata_in = 16'h0000, count_wdata_in = 16'h0000;
  reg compare_a_we_in = 1'b0, compare_b_we_in = 1'b0, capture_top_we_in = 1'b0, count_we_in = 1'b0;
  wire [15:0] count_value_out, compare_a_value_out, capture_top_value_out;
  wire compare_a_flag_out, compare_b_flag_out, capture_flag_out, overflow_flag_out;
  wire wave_out_a_out, wave_out_a_oe_out;
  wire [3:0] fl = {capture_flag_out, compare_b_flag_out, compare_a_flag_out, overflow_flag_out};
  integer err_total = 0, n_checks = 0, per, hi, na, h2, i;
  reg a;
  reg [15:0] v;
  t16wm_timer t16wm_timer_inst (.sys_clk_in, .sys_rst_in, .clk_sel_in, .waveform_mode_sel_in,
    .compare_a_output_mode_in, .compare_b_output_mode_in, .pin_direction_a_in,
    .pin_direction_b_in, .compare_a_wdata_in, .compare_a_we_in, .compare_b_wdata_in,
    .compare_b_we_in, .capture_top_wdata_in, .capture_top_we_in, .count_wdata_in,
    .count_we_in, .count_value_out, .compare_a_value_out, .compare_b_value_out(),
    .capture_top_value_out, .compare_a_flag_out, .compare_b_flag_out, .capture_flag_out,
    .overflow_flag_out, .wave_out_a_out, .wave_out_b_out(), .wave_out_a_oe_out,
    .wave_out_b_oe_out());
  initial begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cfg(input [3:0] m, input [2:0] s, input [1:0] c);
    begin
      @(negedge sys_clk_in);
      waveform_mode_sel_in = m;
      clk_sel_in = s;
      compare_a_output_mode_in = c;
    end
  endtask
  // Strobe bits: 4 compare A, 2 compare B, 1 counter
  task wr(input [2:0] w, input [15:0] d);
    begin
      @(negedge sys_clk_in);
      {compare_a_wdata_in, compare_b_wdata_in, count_wdata_in} = {d, d, d};
      {compare_a_we_in, compare_b_we_in, count_we_in} = w;
      @(negedge sys_clk_in);
      {compare_a_we_in, compare_b_we_in, count_we_in} = 3'h0;
    end
  endtask
  // Cycles up to the next pulse of flag w, with output A high time
  task gap(input integer w, input integer lim);
    begin
      per = 0;
      hi = 0;
      na = 0;
      do begin
        @(negedge sys_clk_in);
        per = per + 1;
        hi = hi + (wave_out_a_out === 1'b1);
        na = na + (compare_a_flag_out === 1'b1);
      end while (fl[w] !== 1'b1 && per < lim);
    end
  endtask
  task t_ctc;
    begin
      cfg(4'h4, 3'h0, 2'h1);
      pin_direction_a_in = 1'b1;
      wr(3'h4, 16'h0002);
      wr(3'h1, 16'h0000);
      cfg(4'h4, 3'h1, 2'h1);
      gap(1, 20);
      gap(1, 20);
      chk(per, 3);
      a = wave_out_a_out;
      gap(1, 20);
      chk(wave_out_a_out, !a);
      chk(wave_out_a_oe_out, 1);
      $display("test ctc done");
    end
  endtask
  task t_wrap;
    begin
      wr(3'h4, 16'h0100);
      wr(3'h1, 16'h0200);
      gap(0, 70000);
      chk(overflow_flag_out, 1);
      chk(na, 0);
      chk(per > 16'hFD00, 1);
      gap(1, 400);
      chk(per < 16'h0110, 1);
      $display("test wrap done");
    end
  endtask
  task t_fast;
    begin
      cfg(4'h5, 3'h1, 2'h2);
      wr(3'h4, 16'h0000);
      gap(0, 600);
      gap(0, 600);
      chk(per, 256);
      h2 = hi;
      cfg(4'h5, 3'h1, 2'h3);
      gap(0, 600);
      gap(0, 600);
      chk(h2 + hi, 256);
      chk(h2 == 1 || h2 == 255, 1);
      wr(3'h4, 16'h00FF);
      gap(0, 600);
      gap(0, 600);
      chk(hi == 0 || hi == 256, 1);
      $display("test fast done");
    end
  endtask
  task t_mask;
    begin
      for (i = 5; i < 8; i = i + 1) begin
        cfg(i, 3'h0, 2'h0);
        wr(3'h4, 16'hFFFF);
        repeat (2) @(negedge sys_clk_in);
        v = 16'h03FF >> (7 - i);
        chk(compare_a_value_out, v);
      end
      $display("test mask done");
    end
  endtask
  task t_buf;
    begin
      cfg(4'hF, 3'h1, 2'h1);
      wr(3'h4, 16'h0009);
      // Old top is still 0x00FF until the first top reload
      gap(0, 300);
      gap(0, 100);
      chk(per, 10);
      a = wave_out_a_out;
      gap(0, 100);
      chk(wave_out_a_out, !a);
      wr(3'h4, 16'h0013);
      gap(0, 100);
      chk(per <= 10, 1);
      gap(0, 100);
      chk(per, 20);
      $display("test buffer done");
    end
  endtask
  task t_block;
    begin
      cfg(4'h5, 3'h1, 2'h0);
      wr(3'h2, 16'h0005);
      gap(0, 600);
      wr(3'h1, 16'h0005);
      gap(2, 200);
      chk(per, 200);
      gap(2, 300);
      chk(compare_b_flag_out, 1);
      $display("test block done");
    end
  endtask
  task t_rate;
    begin
      cfg(4'h5, 3'h2, 2'h0);
      gap(0, 5000);
      gap(0, 5000);
      chk(per, 2048);
      cfg(4'h1, 3'h1, 2'h0);
      gap(0, 1200);
      gap(0, 1200);
      chk(per, 510);
      cfg(4'h5, 3'h0, 2'h0);
      repeat (3) @(negedge sys_clk_in);
      v = count_value_out;
      repeat (50) @(negedge sys_clk_in);
      chk(count_value_out, v);
      $display("test rate done");
    end
  endtask
  // Capture register as fast PWM top; written while stopped to avoid a wrap
  task t_cap;
    begin
      cfg(4'hE, 3'h0, 2'h0);
      @(negedge sys_clk_in);
      capture_top_wdata_in = 16'h0007;
      capture_top_we_in = 1'b1;
      @(negedge sys_clk_in);
      capture_top_we_in = 1'b0;
      wr(3'h1, 16'h0000);
      chk(capture_top_value_out, 16'h0007);
      cfg(4'hE, 3'h1, 2'h0);
      gap(3, 20);
      gap(3, 20);
      chk(per, 8);
      chk(overflow_flag_out, 1);
      $display("test capture done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    chk(count_value_out, 0);
    t_ctc;
    t_wrap;
    t_fast;
    t_mask;
    t_buf;
    t_block;
    t_rate;
    t_cap;
    final_report;
  end
  // Run needs about 72k cycles; 95k means a hang
  initial begin
    #760000;
    err_total = err_total + 1;
    final_report;
  end
endmodule // testbench
bind t16wm_timer t16wm_props #(.WIDTH(WIDTH)) t16wm_props_inst (.sys_clk_in, .sys_rst_in,
  .clk_sel_in, .waveform_mode_sel_in, .compare_a_output_mode_in, .pin_direction_a_in,
  .compare_a_we_in, .compare_b_we_in, .capture_top_we_in, .count_we_in, .count_value_out,
  .compare_a_value_out, .compare_a_flag_out, .overflow_flag_out, .wave_out_a_out,
  .wave_out_a_oe_out);
`default_nettype wire
